// ### rct_map.svh
/*
 * Address map, field positions, reset values and timing counts of the
 * reset-cause block. Assumes a 40 MHz core clock and APB with 32-bit data.
 */
`ifndef RCT_MAP_SVH
`define RCT_MAP_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define RCT_ADDR_W        12
`define RCT_IDX_CSF       8'h03
`define RCT_IDX_RCF       8'h8E
`define RCT_IDX_CFG       8'hA0
`define RCT_IDX_STAT      8'hA1
`define RCT_IDX_IRQ_STAT  8'hA2
`define RCT_IDX_IRQ_MASK  8'hA3

// ==========================================================================
// reset_cause_flags fields
`define RCT_RCF_BOR       0
`define RCT_RCF_POR       1
`define RCT_RCF_SOFTWARE_BROWNOUT_ENABLE    4
`define RCT_RCF_ULTRA_LOW_POWER_WAKE_ENABLE    5
`define RCT_RCF_WMASK     8'h33
`define RCT_RCF_RST       8'h10

// cpu_state_flags fields
`define RCT_CSF_PD        3
`define RCT_CSF_TO        4
`define RCT_CSF_WMASK     8'hE7
`define RCT_CSF_BANKMASK  8'hE0
`define RCT_CSF_RST       8'h18

// configuration fields
`define RCT_CFG_MODE_LO   0
`define RCT_CFG_PWRTDIS   2
`define RCT_CFG_CRYSTAL   3
`define RCT_CFG_RST       8'h00

// interrupt status bits
`define RCT_IRQ_W         7
`define RCT_IRQ_POR       0
`define RCT_IRQ_BOR       1
`define RCT_IRQ_WDTRST    2
`define RCT_IRQ_WDTWAKE   3
`define RCT_IRQ_EXTRST    4
`define RCT_IRQ_INTWAKE   5
`define RCT_IRQ_DONE      6

// ==========================================================================
// timing
`define RCT_CLK_HZ        40000000
`define RCT_LFOSC_HZ      31000
`define RCT_PWRT_TIME_MS  64
`define RCT_OST_PERIODS   1024
`define RCT_LF_DIV        ((`RCT_CLK_HZ + `RCT_LFOSC_HZ - 1) / `RCT_LFOSC_HZ)
`define RCT_PWRT_TICKS    ((`RCT_PWRT_TIME_MS * `RCT_LFOSC_HZ) / 1000)

`endif

// ### rct_pkg.sv
/*
 * Types of the reset-cause block.
 * Assumes rct_map.svh is on the include path.
 */
`include "rct_map.svh"

package rct_pkg;

  // ========================================================================
  // start-up hold sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PWRT, SEQ_OST} rct_seq_state_t;

  // one decoded cause per cycle; after CAUSE_NONE, highest priority first
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_POR, CAUSE_BOR, CAUSE_WDT_RESET,
    CAUSE_WDT_WAKE, CAUSE_EXT_RUN, CAUSE_EXT_SLEEP, CAUSE_INT_WAKE
  } rct_cause_t;

  typedef logic [`RCT_IRQ_W-1:0] rct_irq_vec_t;

endpackage : rct_pkg

// ### rct_seq_if.sv
/*
 * Link between the flag logic and the start-up hold timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps

interface rct_seq_if;
  logic start;
  logic usePwrt;
  logic useOst;
  logic busy;
  logic done;

  modport ctrl  (output start, output usePwrt, output useOst, input busy, input done);
  modport timer (input start, input usePwrt, input useOst, output busy, output done);
endinterface : rct_seq_if

// ### rct_startup_timer.sv
/*
 * Start-up hold timer: power-up period on a divided low-rate tick,
 * then oscillator start-up cycles. Assumes one core clock.
 */
`timescale 1ns/10ps
`include "rct_map.svh"

module rct_startup_timer
  import rct_pkg::*;
#(
  parameter int DIV_CYCLES = `RCT_LF_DIV,
  parameter int PWRT_TICKS = `RCT_PWRT_TICKS,
  parameter int OST_CYCLES = `RCT_OST_PERIODS
) (
  input  wire logic clock,
  input  wire logic rst_n,
  rct_seq_if.timer  seq
);

  localparam int DW = $clog2(DIV_CYCLES + 1);
  localparam int CW = $clog2(((PWRT_TICKS > OST_CYCLES) ? PWRT_TICKS : OST_CYCLES) + 1);
  localparam logic [DW-1:0] DIV_LAST  = DW'(DIV_CYCLES - 1);
  localparam logic [CW-1:0] PWRT_LAST = CW'(PWRT_TICKS - 1);
  localparam logic [CW-1:0] OST_LAST  = CW'(OST_CYCLES - 1);

  rct_seq_state_t  state_q, state_d;
  logic [DW-1:0]   div_q, div_d;
  logic [CW-1:0]   cnt_q, cnt_d;
  logic            ost_q, ost_d;
  logic            done_q, done_d;
  logic            tick;

  // ========================================================================
  // divider: one enable pulse per low-rate oscillator period
  assign tick = (div_q == DIV_LAST);

  // next state; a new start restarts the whole hold, even mid-count
  always_comb begin
    state_d = state_q;
    div_d   = div_q;
    cnt_d   = cnt_q;
    ost_d   = ost_q;
    done_d  = 1'b0;
    if (seq.start) begin
      div_d = '0;
      cnt_d = '0;
      ost_d = seq.useOst;
      if (seq.usePwrt) begin
        state_d = SEQ_PWRT;
      end else if (seq.useOst) begin
        state_d = SEQ_OST;
      end else begin
        state_d = SEQ_IDLE;
      end
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
        end
        SEQ_PWRT: begin
          div_d = tick ? '0 : div_q + 1'b1;
          if (tick) begin
            if (cnt_q == PWRT_LAST) begin
              cnt_d = '0;
              if (ost_q) begin
                state_d = SEQ_OST;
              end else begin
                state_d = SEQ_IDLE;
                done_d  = 1'b1;
              end
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        SEQ_OST: begin
          if (cnt_q == OST_LAST) begin
            state_d = SEQ_IDLE;
            done_d  = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        default: begin
          state_d = SEQ_IDLE;
        end
      endcase
    end
  end

  // registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SEQ_IDLE;
      div_q   <= '0;
      cnt_q   <= '0;
      ost_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q   <= div_d;
      cnt_q   <= cnt_d;
      ost_q   <= ost_d;
      done_q  <= done_d;
    end
  end

  assign seq.busy = (state_q != SEQ_IDLE);
  assign seq.done = done_q;

endmodule : rct_startup_timer

// ### rct_reset_cause.sv
/*
 * Reset-cause flags, start-up hold control and APB register slave.
 * Assumes reset and wake events arrive as one-cycle pulses from logic on
 * the same clock, and that the core obeys coreHold and resumeAtNextPc.
 */
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "rct_map.svh"

// Notes on behaviour
// - reset_cause_flags register at index 8Eh
// - brownout flag cleared by brown-out reset
// - brownout flag meaningless when detection disabled
// - power-on flag cleared only by power-on; here software can also write it through RCT_RCF_WMASK
// - hold length depends on oscillator and timer
// - flags set per documented reset cause
// - reset values 01qq and 0uuu
// - wake keeps registers, resumes at next PC
// - mode 01 lets software switch brown-out
// - power-up timer holds 64 ms at 31 kHz
module rct_reset_cause
  import rct_pkg::*;
#(
  parameter int LF_DIV     = `RCT_LF_DIV,
  parameter int PWRT_TICKS = `RCT_PWRT_TICKS,
  parameter int OST_CYCLES = `RCT_OST_PERIODS
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RCT_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   porEvent,
  input  wire logic                   borEvent,
  input  wire logic                   wdtEvent,
  input  wire logic                   extResetEvent,
  input  wire logic                   intWakeEvent,
  input  wire logic                   sleepActive,
  output logic                        coreHold,
  output logic                        resumeAtNextPc,
  output logic                        borDetectEnable,
  output logic                        irq
);

  // ========================================================================
  // address decode helper
  function automatic logic regHit(input logic [`RCT_ADDR_W-1:0] addr,
                                  input logic [7:0]             idx);
    regHit = (addr == {2'b00, idx, 2'b00});
  endfunction : regHit

  // ========================================================================
  // state
  logic [7:0]    rcf_q, rcf_d;       // reset_cause_flags
  logic [7:0]    csf_q, csf_d;       // cpu_state_flags
  logic [7:0]    cfg_q, cfg_d;
  rct_irq_vec_t  ist_q, ist_d;
  rct_irq_vec_t  imask_q, imask_d;
  logic          irq_q, irq_d;
  logic          hold_q, hold_d;
  logic          resume_q, resume_d;
  logic          brownout_mode_field_q, brownout_mode_field_d;
  logic [31:0]   prdata_q, prdata_d;
  logic          pready_q, pready_d;
  logic          pslverr_q, pslverr_d;

  logic          setupPhase;
  logic          wrDone;
  logic          mapped;
  rct_cause_t    cause;
  logic          resetType;
  logic          wakeType;
  logic [1:0]    borMode;
  logic [31:0]   rdMux;
  rct_irq_vec_t  events;

  rct_seq_if seq ();

  rct_startup_timer #(
    .DIV_CYCLES (LF_DIV),
    .PWRT_TICKS (PWRT_TICKS),
    .OST_CYCLES (OST_CYCLES)
  ) u_timer (
    .clock (clock),
    .rst_n (rst_n),
    .seq   (seq.timer)
  );

  // ========================================================================
  // APB slave: answer is prepared in the setup cycle, so the access phase
  // always completes in its first cycle; writes land at that edge only
  assign setupPhase = psel & ~penable;
  assign wrDone     = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign mapped     = regHit(paddr, `RCT_IDX_CSF) | regHit(paddr, `RCT_IDX_RCF)
                    | regHit(paddr, `RCT_IDX_CFG) | regHit(paddr, `RCT_IDX_STAT)
                    | regHit(paddr, `RCT_IDX_IRQ_STAT) | regHit(paddr, `RCT_IDX_IRQ_MASK);

  // read mux; narrow registers sit in the low bits, upper bits read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    if (regHit(paddr, `RCT_IDX_CSF)) begin
      rdMux[7:0] = csf_q;
    end else if (regHit(paddr, `RCT_IDX_RCF)) begin
      rdMux[7:0] = rcf_q;
    end else if (regHit(paddr, `RCT_IDX_CFG)) begin
      rdMux[7:0] = cfg_q;
    end else if (regHit(paddr, `RCT_IDX_STAT)) begin
      rdMux[3:0] = {seq.busy, brownout_mode_field_q, resume_q, hold_q};
    end else if (regHit(paddr, `RCT_IDX_IRQ_STAT)) begin
      rdMux[`RCT_IRQ_W-1:0] = ist_q;
    end else if (regHit(paddr, `RCT_IDX_IRQ_MASK)) begin
      rdMux[`RCT_IRQ_W-1:0] = imask_q;
    end
  end

  // bus answer registers
  always_comb begin
    pready_d  = setupPhase;
    pslverr_d = setupPhase & ~mapped;
    prdata_d  = prdata_q;
    if (setupPhase) begin
      prdata_d = (pwrite | ~mapped) ? 32'h0000_0000 : rdMux;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ========================================================================
  // cause decode: one cause per cycle, power-on first; a brown-out pulse
  // is only believed while detection is enabled
  assign borMode = cfg_q[`RCT_CFG_MODE_LO +: 2];

  always_comb begin
    if (porEvent) begin
      cause = CAUSE_POR;
    end else if (borEvent & brownout_mode_field_q) begin
      cause = CAUSE_BOR;
    end else if (wdtEvent) begin
      cause = sleepActive ? CAUSE_WDT_WAKE : CAUSE_WDT_RESET;
    end else if (extResetEvent) begin
      cause = sleepActive ? CAUSE_EXT_SLEEP : CAUSE_EXT_RUN;
    end else if (intWakeEvent & sleepActive) begin
      cause = CAUSE_INT_WAKE;
    end else begin
      cause = CAUSE_NONE;
    end
  end

  assign wakeType  = (cause == CAUSE_WDT_WAKE) | (cause == CAUSE_INT_WAKE);
  assign resetType = (cause != CAUSE_NONE) & ~wakeType;

  // start-up hold request: power-up timer only on power-on or brown-out
  assign seq.start   = (cause == CAUSE_POR) | (cause == CAUSE_BOR) | wakeType;
  assign seq.usePwrt = ~wakeType & ~cfg_q[`RCT_CFG_PWRTDIS];
  assign seq.useOst  = cfg_q[`RCT_CFG_CRYSTAL];

  // ========================================================================
  // flags: software writes first, then the hardware cause overrides, so an
  // event in the same cycle as a write always wins
  always_comb begin
    rcf_d = rcf_q;
    csf_d = csf_q;
    cfg_d = cfg_q;
    if (wrDone && regHit(paddr, `RCT_IDX_RCF)) begin
      rcf_d = (rcf_q & ~`RCT_RCF_WMASK) | (pwdata[7:0] & `RCT_RCF_WMASK);
    end
    if (wrDone && regHit(paddr, `RCT_IDX_CSF)) begin
      csf_d = (csf_q & ~`RCT_CSF_WMASK) | (pwdata[7:0] & `RCT_CSF_WMASK);
    end
    if (wrDone && regHit(paddr, `RCT_IDX_CFG)) begin
      cfg_d = {4'h0, pwdata[3:0]};
    end
    unique case (cause)
      CAUSE_POR: begin
        rcf_d[`RCT_RCF_POR]    = 1'b0;
        rcf_d[`RCT_RCF_ULTRA_LOW_POWER_WAKE_ENABLE] = 1'b0;
        rcf_d[`RCT_RCF_SOFTWARE_BROWNOUT_ENABLE] = 1'b1;
        csf_d[`RCT_CSF_TO]     = 1'b1;
        csf_d[`RCT_CSF_PD]     = 1'b1;
        csf_d                  = csf_d & ~`RCT_CSF_BANKMASK;
      end
      CAUSE_BOR: begin
        rcf_d[`RCT_RCF_BOR]    = 1'b0;
        rcf_d[`RCT_RCF_ULTRA_LOW_POWER_WAKE_ENABLE] = 1'b0;
        rcf_d[`RCT_RCF_SOFTWARE_BROWNOUT_ENABLE] = 1'b1;
        csf_d[`RCT_CSF_TO]     = 1'b1;
        csf_d[`RCT_CSF_PD]     = 1'b1;
        csf_d                  = csf_d & ~`RCT_CSF_BANKMASK;
      end
      CAUSE_WDT_RESET: begin
        csf_d[`RCT_CSF_TO]     = 1'b0;
        rcf_d[`RCT_RCF_ULTRA_LOW_POWER_WAKE_ENABLE] = 1'b0;
        csf_d                  = csf_d & ~`RCT_CSF_BANKMASK;
      end
      CAUSE_WDT_WAKE: begin
        csf_d[`RCT_CSF_TO]     = 1'b0;
        csf_d[`RCT_CSF_PD]     = 1'b0;
      end
      CAUSE_EXT_SLEEP: begin
        csf_d[`RCT_CSF_TO]     = 1'b1;
        csf_d[`RCT_CSF_PD]     = 1'b0;
        rcf_d[`RCT_RCF_ULTRA_LOW_POWER_WAKE_ENABLE] = 1'b0;
        csf_d                  = csf_d & ~`RCT_CSF_BANKMASK;
      end
      CAUSE_EXT_RUN: begin
        rcf_d[`RCT_RCF_ULTRA_LOW_POWER_WAKE_ENABLE] = 1'b0;
        csf_d                  = csf_d & ~`RCT_CSF_BANKMASK;
      end
      CAUSE_INT_WAKE: begin
        csf_d[`RCT_CSF_TO]     = 1'b1;
        csf_d[`RCT_CSF_PD]     = 1'b0;
      end
      CAUSE_NONE: begin
      end
    endcase
  end

  // ========================================================================
  // core control: hold while any reset is seen or the timer runs; a wake
  // resumes at the next instruction, any reset goes to the vector
  always_comb begin
    hold_d   = resetType | seq.start | seq.busy;
    resume_d = resume_q;
    if (wakeType) begin
      resume_d = 1'b1;
    end else if (resetType) begin
      resume_d = 1'b0;
    end
    unique case (borMode)
      2'b00:   brownout_mode_field_d = 1'b0;
      2'b01:   brownout_mode_field_d = rcf_d[`RCT_RCF_SOFTWARE_BROWNOUT_ENABLE];
      2'b10:   brownout_mode_field_d = ~sleepActive;
      2'b11:   brownout_mode_field_d = 1'b1;
    endcase
  end

  // ========================================================================
  // interrupts: sticky causes, write one to clear, set beats clear
  always_comb begin
    events                   = '0;
    events[`RCT_IRQ_POR]     = (cause == CAUSE_POR);
    events[`RCT_IRQ_BOR]     = (cause == CAUSE_BOR);
    events[`RCT_IRQ_WDTRST]  = (cause == CAUSE_WDT_RESET);
    events[`RCT_IRQ_WDTWAKE] = (cause == CAUSE_WDT_WAKE);
    events[`RCT_IRQ_EXTRST]  = (cause == CAUSE_EXT_RUN) | (cause == CAUSE_EXT_SLEEP);
    events[`RCT_IRQ_INTWAKE] = (cause == CAUSE_INT_WAKE);
    events[`RCT_IRQ_DONE]    = seq.done;
    ist_d   = ist_q;
    imask_d = imask_q;
    if (wrDone && regHit(paddr, `RCT_IDX_IRQ_STAT)) begin
      ist_d = ist_q & ~pwdata[`RCT_IRQ_W-1:0];
    end
    if (wrDone && regHit(paddr, `RCT_IDX_IRQ_MASK)) begin
      imask_d = pwdata[`RCT_IRQ_W-1:0];
    end
    ist_d = ist_d | events;
    irq_d = |(ist_d & imask_d);
  end

  // ========================================================================
  // state registers; async reset acts as a power-on image of the flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rcf_q    <= `RCT_RCF_RST;
      csf_q    <= `RCT_CSF_RST;
      cfg_q    <= `RCT_CFG_RST;
      ist_q    <= '0;
      imask_q  <= '0;
      irq_q    <= 1'b0;
      hold_q   <= 1'b1;
      resume_q <= 1'b0;
      brownout_mode_field_q  <= 1'b0;
    end else begin
      rcf_q    <= rcf_d;
      csf_q    <= csf_d;
      cfg_q    <= cfg_d;
      ist_q    <= ist_d;
      imask_q  <= imask_d;
      irq_q    <= irq_d;
      hold_q   <= hold_d;
      resume_q <= resume_d;
      brownout_mode_field_q  <= brownout_mode_field_d;
    end
  end

  // every output straight from a flop
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign coreHold        = hold_q;
  assign resumeAtNextPc  = resume_q;
  assign borDetectEnable = brownout_mode_field_q;
  assign irq             = irq_q;

endmodule : rct_reset_cause

// ### rct_reset_cause_properties.sv
/*
 * Port-level checker for the reset-cause block.
 * Assumes one core clock and the active-low asynchronous reset.
 */
`timescale 1ns/10ps

// ==========================================================================
// checker
module rct_reset_cause_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic porEvent,
  input wire logic borEvent,
  input wire logic wdtEvent,
  input wire logic extResetEvent,
  input wire logic intWakeEvent,
  input wire logic sleepActive,
  input wire logic coreHold,
  input wire logic resumeAtNextPc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // a running reset holds the core for exactly one cycle
  sequence sHoldPulse;
    ##1 (coreHold && !resumeAtNextPc) ##1 !coreHold;
  endsequence

  logic noResetEv;
  assign noResetEv = !porEvent && !borEvent;

  pready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  pready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  por_hold_a: assert property (porEvent |=> coreHold && !resumeAtNextPc)
    else $error("power-on did not hold core");
  run_reset_pulse_a: assert property ((wdtEvent || extResetEvent) && !sleepActive
    && noResetEv && !coreHold |-> sHoldPulse)
    else $error("running reset hold wrong");
  wdt_wake_resume_a: assert property (wdtEvent && sleepActive && noResetEv
    |-> ##2 resumeAtNextPc)
    else $error("watchdog wake lost resume");
  int_wake_resume_a: assert property (intWakeEvent && sleepActive && noResetEv
    && !wdtEvent && !extResetEvent |-> ##2 resumeAtNextPc)
    else $error("interrupt wake lost resume");
endmodule : rct_reset_cause_properties

bind rct_reset_cause rct_reset_cause_properties u_props (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .porEvent(porEvent),
  .borEvent(borEvent), .wdtEvent(wdtEvent), .extResetEvent(extResetEvent),
  .intWakeEvent(intWakeEvent), .sleepActive(sleepActive),
  .coreHold(coreHold), .resumeAtNextPc(resumeAtNextPc));

// ### rct_detector_model.sv
/*
 * Model of the reset detectors and sleep state beside the block.
 * Assumes the bench raises go for one cycle with the wanted kind.
 */
`timescale 1ns/10ps

// ==========================================================================
// detector model
module rct_detector_model (
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [2:0] kind,
  input  wire logic       sleepReq,
  output logic            porEvent,
  output logic            borEvent,
  output logic            wdtEvent,
  output logic            extResetEvent,
  output logic            intWakeEvent,
  output logic            sleepActive
);
  // one-cycle pulses, registered so they never race the sampling edge
  always_ff @(posedge clock) begin
    porEvent      <= go && kind == 3'h1;
    borEvent      <= go && kind == 3'h2;
    wdtEvent      <= go && kind == 3'h3;
    extResetEvent <= go && kind == 3'h4;
    intWakeEvent  <= go && kind == 3'h5;
    sleepActive   <= sleepReq;
  end
endmodule : rct_detector_model

// ### rct_reset_cause_tb.sv
/*
 * Self-checking bench for the reset-cause block.
 * Assumes shortened hold counts and the detector model beside it.
 */
`timescale 1ns/10ps

module rct_reset_cause_tb;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic go = 0, sleepReq = 0;
  logic [2:0] kind = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, coreHold, resumeAtNextPc, borDetectEnable, irq;
  logic porEvent, borEvent, wdtEvent, extResetEvent, intWakeEvent, sleepActive;
  int mismatches = 0, num_checks = 0, n;
  localparam logic [11:0] CSF = 12'h00C, RCF = 12'h238, CFG = 12'h280;

  always #12.5 clock = ~clock;

  rct_detector_model model (.clock(clock), .go(go), .kind(kind), .sleepReq(sleepReq),
    .porEvent(porEvent), .borEvent(borEvent), .wdtEvent(wdtEvent),
    .extResetEvent(extResetEvent), .intWakeEvent(intWakeEvent), .sleepActive(sleepActive));

  rct_reset_cause #(.LF_DIV(3), .PWRT_TICKS(4), .OST_CYCLES(5)) dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .porEvent(porEvent), .borEvent(borEvent), .wdtEvent(wdtEvent),
    .extResetEvent(extResetEvent), .intWakeEvent(intWakeEvent), .sleepActive(sleepActive),
    .coreHold(coreHold), .resumeAtNextPc(resumeAtNextPc),
    .borDetectEnable(borDetectEnable), .irq(irq));

  // ========================================================================
  // shared tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // one transfer; held until ready is sampled high at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    // no wait limit here: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  // fire one event and count the cycles the core stays held beyond its first
  task fire(input logic [2:0] k);
    @(posedge clock);
    go <= 1; kind <= k;
    @(posedge clock);
    go <= 0;
    n = 0;
    repeat (3) @(posedge clock);
    while (coreHold === 1'b1) begin
      @(posedge clock);
      n++;
    end
  endtask : fire

  // ========================================================================
  // scenarios
  task tBus;
    apb(0, RCF, 0); chk("rcf reset", rd, 32'h10);
    apb(1, CSF, 0); apb(0, CSF, 0); chk("csf ro", rd, 32'h18);
    apb(0, 12'h100, 0); chk("unmapped err", err, 1); chk("unmapped data", rd, 0);
  endtask : tBus

  task tPor;
    apb(1, CFG, 32'h08); apb(1, RCF, 32'h33); apb(1, CSF, 32'hE7);
    fire(1);
    chk("por hold", n >= 15 && n <= 30, 1);
    apb(0, RCF, 0); chk("rcf por", rd, 32'h11);
    apb(0, CSF, 0); chk("csf por", rd, 32'h1F);
    chk("resume por", resumeAtNextPc, 0);
  endtask : tPor

  task tRun;
    apb(1, RCF, 32'h33);
    fire(4);
    chk("ext hold", n, 0);
    apb(0, RCF, 0); chk("rcf ext", rd, 32'h13);
    apb(0, CSF, 0); chk("csf ext", rd, 32'h1F);
    fire(3); apb(0, CSF, 0); chk("csf wdt", rd, 32'h0F);
    apb(0, RCF, 0); chk("rcf wdt", rd, 32'h13);
  endtask : tRun

  task tBor;
    apb(1, CFG, 32'h04); fire(1); chk("no pwrt hold", n <= 3, 1);
    apb(1, CFG, 32'h01); apb(1, RCF, 32'h03);
    repeat (2) @(posedge clock); chk("sw bor off", borDetectEnable, 0);
    fire(2); apb(0, RCF, 0); chk("bor ignored", rd, 32'h03);
    apb(1, RCF, 32'h13);
    repeat (2) @(posedge clock); chk("sw bor on", borDetectEnable, 1);
    fire(2); apb(0, RCF, 0); chk("rcf bor", rd, 32'h12);
    apb(0, CSF, 0); chk("csf bor", rd[4:3], 2'b11);
    // mode 10 drops detection in sleep, mode 11 keeps it on regardless
    apb(1, CFG, 32'h02);
    sleepReq <= 1;
    repeat (3) @(posedge clock);
    chk("bor sleep off", borDetectEnable, 0);
    apb(1, CFG, 32'h03);
    repeat (3) @(posedge clock);
    chk("bor forced on", borDetectEnable, 1);
    sleepReq <= 0;
  endtask : tBor

  // sleep cases: wdt wake, ext in sleep, int wake, int while awake
  task automatic tSleep;
    logic [2:0] ks[4] = '{3'h3, 3'h4, 3'h5, 3'h5};
    logic [1:0] fl[4] = '{2'b00, 2'b10, 2'b10, 2'b11};
    logic       rs[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    apb(1, CFG, 32'h08);
    for (int i = 0; i < 4; i++) begin
      fire(1);
      sleepReq <= i < 3;
      fire(ks[i]);
      chk("resume", resumeAtNextPc, rs[i]);
      sleepReq <= 0;
      apb(0, CSF, 0); chk("csf sleep", rd[4:3], fl[i]);
    end
  endtask : tSleep

  task tIrq;
    apb(1, 12'h28C, 0); repeat (2) @(posedge clock); chk("irq masked", irq, 0);
    apb(1, 12'h28C, 1); repeat (2) @(posedge clock); chk("irq on", irq, 1);
    apb(1, 12'h288, 32'h7F); repeat (2) @(posedge clock); chk("irq clr", irq, 0);
  endtask : tIrq

  // ========================================================================
  // verdict and run control
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1;
    tBus(); tPor(); tRun(); tBor(); tSleep(); tIrq();
    summarize();
  end
endmodule : rct_reset_cause_tb
